// [cpsw_top.sv]
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "cpsw_cfg.svh"

// Notes on behaviour
// - Mode field 00 keeps the CPU running in its normal mode.
// - Writing mode 01 puts the device into the idle power-down state.
// - Writing mode 10 puts the device into the stop power-down state.
// - Clock select 00, 10, 11 runs the CPU clock at system clock / 64, / 8, / 4.
// - The carry flag reads 1 after an overflow or borrow and 0 otherwise.
// - Interrupt status 00 serves all, 01 only selected high priority, 10 none, 11 undefined.
// - With the master enable clear no interrupt is served whatever the status holds.
module cpsw_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        carry_we_in,
  input  wire logic        carry_in,
  input  wire logic [2:0]  skip_set_in,
  input  wire logic        skip_clr_in,
  input  wire logic        wake_in,
  input  wire logic        int_req_in,
  input  wire logic        int_req_high_in,
  output logic             cpu_clk_en_out,
  output logic             idle_out,
  output logic             stop_out,
  output logic             carry_out,
  output logic [2:0]       skip_flags_out,
  output logic [1:0]       int_status_out,
  output logic             mem_bank_enable_out,
  output logic             reg_bank_enable_out,
  output logic             int_service_out
);

  cpsw_pkg::cpsw_pwr_e state_ff;
  cpsw_pkg::cpsw_pwr_e nxt_state;
  logic [1:0]  clk_sel_ff;
  logic        ime_ff;
  logic [2:0]  prio_sel_ff;
  logic        carry_ff;
  logic        nxt_carry;
  logic [2:0]  skip_ff;
  logic [2:0]  nxt_skip;
  logic [1:0]  is_ff;
  logic [1:0]  nxt_is;
  logic        emb_ff;
  logic        nxt_emb;
  logic        erb_ff;
  logic        nxt_erb;
  logic        dp_wr_ff;
  logic [13:0] dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic        ap_valid;
  logic        wr_psw;
  logic        wr_power_control;
  logic        wr_prio;
  logic [1:0]  wr_mode;
  logic        pd_seen_ff;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign ap_valid      = hsel_in && hready_in && htrans_in[1];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_ff;
  assign wr_psw        = dp_wr_ff && (dp_addr_ff == `CPSW_ADDR_PSW);
  assign wr_power_control       = dp_wr_ff && (dp_addr_ff == `CPSW_ADDR_POWER_CONTROL);
  assign wr_prio       = dp_wr_ff && (dp_addr_ff == `CPSW_ADDR_PRIO);
  assign wr_mode       = hwdata_in[`CPSW_POWER_CONTROL_MODE_HI:`CPSW_POWER_CONTROL_MODE_LO];

  // Address phase capture
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 14'h0;
    end else begin
      dp_wr_ff   <= ap_valid && hwrite_in;
      dp_addr_ff <= haddr_in[13:0];
    end
  end

  // Read data from next values, so a write just before is seen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hrdata_ff <= 32'h0;
    end else if (ap_valid && !hwrite_in) begin
      if (haddr_in == {18'h0, `CPSW_ADDR_PSW}) begin
        hrdata_ff <= {24'h0, nxt_carry, nxt_skip, nxt_is, nxt_emb, nxt_erb};
      end else begin
        hrdata_ff <= 32'h0; // Write-only and unmapped words read zero
      end
    end
  end

  // ==========================================================
  // Power control: clock select and priority register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk_sel_ff <= 2'(`CPSW_POWER_CONTROL_RST);
    end else if (wr_power_control) begin
      clk_sel_ff <= hwdata_in[`CPSW_POWER_CONTROL_CLK_HI:`CPSW_POWER_CONTROL_CLK_LO];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {ime_ff, prio_sel_ff} <= `CPSW_PRIO_RST;
    end else if (wr_prio) begin
      {ime_ff, prio_sel_ff} <= hwdata_in[3:0];
    end
  end

  // Power state machine; a wake event returns to normal
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cpsw_pkg::CPSW_NORMAL: begin
        if (wr_power_control && wr_mode == cpsw_pkg::CPSW_MODE_IDLE) begin
          nxt_state = cpsw_pkg::CPSW_IDLE;
        end else if (wr_power_control && wr_mode == cpsw_pkg::CPSW_MODE_STOP) begin
          nxt_state = cpsw_pkg::CPSW_STOP;
        end
      end
      cpsw_pkg::CPSW_IDLE: begin
        if (wake_in) nxt_state = cpsw_pkg::CPSW_NORMAL;
      end
      cpsw_pkg::CPSW_STOP: begin
        if (wake_in) nxt_state = cpsw_pkg::CPSW_NORMAL;
      end
      default: nxt_state = cpsw_pkg::CPSW_NORMAL;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= cpsw_pkg::CPSW_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign idle_out = (state_ff == cpsw_pkg::CPSW_IDLE);
  assign stop_out = (state_ff == cpsw_pkg::CPSW_STOP);

  // CPU clock enable runs only in normal mode
  cpsw_clkdiv i_cpsw_clkdiv (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (state_ff == cpsw_pkg::CPSW_NORMAL),
    .sel_in   (clk_sel_ff),
    .tick_out (cpu_clk_en_out)
  );

  // ==========================================================
  // Program status word next values
  always_comb begin
    nxt_carry = carry_ff;
    nxt_skip  = skip_ff;
    nxt_is    = is_ff;
    nxt_emb   = emb_ff;
    nxt_erb   = erb_ff;
    if (wr_psw) begin
      nxt_carry = hwdata_in[`CPSW_PSW_CARRY];
      nxt_is    = hwdata_in[`CPSW_PSW_IS_HI:`CPSW_PSW_IS_LO];
      nxt_emb   = hwdata_in[`CPSW_PSW_EMB];
      nxt_erb   = hwdata_in[`CPSW_PSW_ERB];
    end
    if (carry_we_in) nxt_carry = carry_in;
    if (skip_clr_in) nxt_skip = `CPSW_SKIP_RST;
    nxt_skip = nxt_skip | skip_set_in;
  end

  // Power-down flag frozen by reset, so carry survives a reset of any length
  always_ff @(posedge clk_in) begin
    if (rst_n_in) begin
      pd_seen_ff <= (nxt_state != cpsw_pkg::CPSW_NORMAL);
    end
  end

  // Carry is kept over a reset taken in power-down
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      carry_ff <= pd_seen_ff ? carry_ff : `CPSW_CARRY_RST;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      skip_ff <= `CPSW_SKIP_RST;
      is_ff   <= `CPSW_IS_RST;
      emb_ff  <= 1'b0;
      erb_ff  <= 1'b0;
    end else begin
      skip_ff <= nxt_skip;
      is_ff   <= nxt_is;
      emb_ff  <= nxt_emb;
      erb_ff  <= nxt_erb;
    end
  end

  assign carry_out           = carry_ff;
  assign skip_flags_out      = skip_ff;
  assign int_status_out      = is_ff;
  assign mem_bank_enable_out = emb_ff;
  assign reg_bank_enable_out = erb_ff;

  // ==========================================================
  // Interrupt service gating by master enable and status
  always_comb begin
    int_service_out = 1'b0;
    if (ime_ff) begin
      case (cpsw_pkg::cpsw_is_e'(is_ff))
        cpsw_pkg::CPSW_IS_ALL:  int_service_out = int_req_in;
        cpsw_pkg::CPSW_IS_HIGH: int_service_out = int_req_high_in;
        default:                int_service_out = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  logic [6:0] gap_ff;

  // Cycles since the last tick; all ones marks a gap broken by reset, a power control write or a power-down state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || wr_power_control || state_ff != cpsw_pkg::CPSW_NORMAL) begin
      gap_ff <= 7'h7f;
    end else if (cpu_clk_en_out) begin
      gap_ff <= 7'h0;
    end else if (gap_ff != 7'h7f) begin
      gap_ff <= gap_ff + 7'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_idle_entry: assert property (
    state_ff == cpsw_pkg::CPSW_NORMAL && wr_power_control && wr_mode == 2'h1
    |=> (idle_out && !cpu_clk_en_out) [*3])
    else $error("idle mode not entered");

  a_stop_entry: assert property (
    state_ff == cpsw_pkg::CPSW_NORMAL && wr_power_control && wr_mode == 2'h2
    |=> stop_out && !idle_out)
    else $error("stop mode not entered");

  a_normal_runs: assert property (
    cpu_clk_en_out |-> state_ff == cpsw_pkg::CPSW_NORMAL)
    else $error("cpu clock ticks outside normal mode");

  a_div_sixty4: assert property (
    cpu_clk_en_out && clk_sel_ff == 2'h0 && gap_ff != 7'h7f |-> gap_ff == 7'd63)
    else $error("divide by 64 period wrong");

  a_div_fast: assert property (
    cpu_clk_en_out && clk_sel_ff == 2'h3 && state_ff == cpsw_pkg::CPSW_NORMAL && !wr_power_control
    ##1 (!wr_power_control && state_ff == cpsw_pkg::CPSW_NORMAL) [*4]
    |-> cpu_clk_en_out && $past(cpu_clk_en_out, 4))
    else $error("divide by 4 period wrong");

  a_carry_track: assert property (
    carry_we_in |=> carry_out == $past(carry_in))
    else $error("carry flag not updated");

  a_skip_keep: assert property (
    wr_psw && skip_set_in == 3'h0 && !skip_clr_in |=> $stable(skip_flags_out))
    else $error("software changed skip flags");

  a_status_gate: assert property (
    int_service_out |-> (is_ff == 2'h0 && int_req_in) || (is_ff == 2'h1 && int_req_high_in))
    else $error("interrupt served against status");

  a_ime_block: assert property (
    !ime_ff |-> !int_service_out)
    else $error("interrupt served with master enable clear");

  c_idle_wake: cover property (idle_out ##[1:20] !idle_out);
  c_stop_wake: cover property (stop_out ##[1:20] !stop_out);
  c_high_only: cover property (int_service_out && is_ff == 2'h1);
  c_psw_write: cover property (wr_psw ##1 skip_flags_out != 3'h0);

endmodule : cpsw_top

// [cpsw_cfg.svh]
`ifndef CPSW_CFG_SVH
`define CPSW_CFG_SVH

// ==========================================================
// Register indices and byte addresses (byte address = 4 * index)
`define CPSW_IDX_PSW       12'hfb0
`define CPSW_IDX_PRIO      12'hfb2
`define CPSW_IDX_POWER_CONTROL      12'hfb3
`define CPSW_ADDR_PSW      14'h3ec0
`define CPSW_ADDR_PRIO     14'h3ec8
`define CPSW_ADDR_POWER_CONTROL     14'h3ecc

// ==========================================================
// Field positions
`define CPSW_POWER_CONTROL_MODE_HI  3
`define CPSW_POWER_CONTROL_MODE_LO  2
`define CPSW_POWER_CONTROL_CLK_HI   1
`define CPSW_POWER_CONTROL_CLK_LO   0
`define CPSW_PSW_CARRY     7
`define CPSW_PSW_SKIP_HI   6
`define CPSW_PSW_SKIP_LO   4
`define CPSW_PSW_IS_HI     3
`define CPSW_PSW_IS_LO     2
`define CPSW_PSW_EMB       1
`define CPSW_PSW_ERB       0
`define CPSW_PRIO_IME      3

// ==========================================================
// Reset values
`define CPSW_POWER_CONTROL_RST      4'h0
`define CPSW_PRIO_RST      4'h0
`define CPSW_SKIP_RST      3'h0
`define CPSW_IS_RST        2'h0
`define CPSW_CARRY_RST     1'h0

// ==========================================================
// Clock divider ratios of the system clock
`define CPSW_DIV_SLOW      64
`define CPSW_DIV_MID       8
`define CPSW_DIV_FAST      4

`endif

// [cpsw_pkg.sv]
package cpsw_pkg;

  // ==========================================================
  // Power state, Gray coded along normal -> idle -> stop
  typedef enum logic [1:0] {
    CPSW_NORMAL = 2'h0,
    CPSW_IDLE   = 2'h1,
    CPSW_STOP   = 2'h3
  } cpsw_pwr_e;

  // Operating mode field codes
  typedef enum logic [1:0] {
    CPSW_MODE_NORMAL = 2'h0,
    CPSW_MODE_IDLE   = 2'h1,
    CPSW_MODE_STOP   = 2'h2,
    CPSW_MODE_RSVD   = 2'h3
  } cpsw_mode_e;

  // Clock select codes
  typedef enum logic [1:0] {
    CPSW_CLK_DIV64 = 2'h0,
    CPSW_CLK_RSVD  = 2'h1,
    CPSW_CLK_DIV8  = 2'h2,
    CPSW_CLK_DIV4  = 2'h3
  } cpsw_clk_e;

  // Interrupt status codes
  typedef enum logic [1:0] {
    CPSW_IS_ALL  = 2'h0,
    CPSW_IS_HIGH = 2'h1,
    CPSW_IS_NONE = 2'h2,
    CPSW_IS_UNDF = 2'h3
  } cpsw_is_e;

endpackage : cpsw_pkg

// [cpsw_clkdiv.sv]
`timescale 1ns/1ps
`include "cpsw_cfg.svh"

module cpsw_clkdiv #(
  parameter int DIV_SLOW = `CPSW_DIV_SLOW,
  parameter int DIV_MID  = `CPSW_DIV_MID,
  parameter int DIV_FAST = `CPSW_DIV_FAST
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);

  logic [6:0] cnt_ff;
  logic [6:0] limit;

  // ==========================================================
  // Divisor selection; the unlisted code keeps the slowest rate
  always_comb begin
    case (cpsw_pkg::cpsw_clk_e'(sel_in))
      cpsw_pkg::CPSW_CLK_DIV8: limit = 7'(DIV_MID - 1);
      cpsw_pkg::CPSW_CLK_DIV4: limit = 7'(DIV_FAST - 1);
      default:                 limit = 7'(DIV_SLOW - 1);
    endcase
  end

  // Free count while running, held at zero when halted
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !run_in) begin
      cnt_ff <= 7'h0;
    end else if (cnt_ff >= limit) begin
      cnt_ff <= 7'h0;
    end else begin
      cnt_ff <= cnt_ff + 7'h1;
    end
  end

  // One system clock wide CPU clock enable
  assign tick_out = run_in && (cnt_ff >= limit);

endmodule : cpsw_clkdiv

// [cpsw_tb_top.sv]
`timescale 1ns/1ps
`include "cpsw_cfg.svh"

module cpsw_tb_top;
  // ==========================================================
  // Signals and stimulus table
  localparam logic [31:0] A_PSW  = 32'(`CPSW_ADDR_PSW);
  localparam logic [31:0] A_PRIO = 32'(`CPSW_ADDR_PRIO);
  localparam logic [31:0] A_POWER_CONTROL = 32'(`CPSW_ADDR_POWER_CONTROL);
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] rd;
    logic       req;
    logic       hi;
    logic       srv;
  } cpsw_row_s;
  cpsw_row_s   rows [5] = '{'{8'h7f, 8'h0f, 1'b1, 1'b1, 1'b0}, '{8'h83, 8'h83, 1'b1, 1'b0, 1'b1},
                            '{8'h04, 8'h04, 1'b1, 1'b0, 1'b0}, '{8'h06, 8'h06, 1'b0, 1'b1, 1'b1},
                            '{8'h09, 8'h09, 1'b1, 1'b1, 1'b0}};
  logic        clk_in, rst_n_in, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, is;
  logic [2:0]  hsize, skip_set, skip;
  logic        carry_we, carry_v, skip_clr, wake, req, req_hi;
  logic        tick, idle, stop, carry, mem_bank_enable, reg_bank_enable, srv;
  int          fails, checked;

  assign hready = hreadyout;

  cpsw_top i_cpsw_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .carry_we_in(carry_we), .carry_in(carry_v), .skip_set_in(skip_set),
    .skip_clr_in(skip_clr), .wake_in(wake), .int_req_in(req), .int_req_high_in(req_hi),
    .cpu_clk_en_out(tick), .idle_out(idle), .stop_out(stop), .carry_out(carry),
    .skip_flags_out(skip), .int_status_out(is), .mem_bank_enable_out(mem_bank_enable),
    .reg_bank_enable_out(reg_bank_enable), .int_service_out(srv)
  );

  // Clock generator, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ==========================================================
  // Tasks
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for hready at a rising edge, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      final_report();
    end
  endtask : wait_rdy

  // One AHB single transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(x, exp);
  endtask : rd_chk

  // Core-side pulses for one cycle
  task automatic hw(input logic cw, input logic cv, input logic [2:0] ss, input logic sc);
    carry_we <= cw;
    carry_v  <= cv;
    skip_set <= ss;
    skip_clr <= sc;
    @(posedge clk_in);
    carry_we <= 1'b0;
    skip_set <= 3'h0;
    skip_clr <= 1'b0;
    @(posedge clk_in);
  endtask : hw

  // Measures the spacing of two CPU clock ticks
  task automatic period(input int exp);
    int n;
    n = 0;
    #1;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 200);
    chk(32'(n), 32'(exp));
    @(posedge clk_in);
  endtask : period

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    fails = 0; checked = 0; rst_n_in = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; carry_we = 1'b0; carry_v = 1'b0;
    skip_set = 3'h0; skip_clr = 1'b0; wake = 1'b0; req = 1'b0; req_hi = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    wr(A_PRIO, 32'h8);
    // Status codes, bank flags and service selection from the table
    foreach (rows[i]) begin
      req    <= rows[i].req;
      req_hi <= rows[i].hi;
      wr(A_PSW, 32'(rows[i].wd));
      rd_chk(A_PSW, 32'(rows[i].rd));
      #1;
      chk(32'(is), 32'(rows[i].wd[3:2]));
      chk(32'(srv), 32'(rows[i].srv));
      chk(32'({carry, mem_bank_enable, reg_bank_enable}), 32'({rows[i].wd[7], rows[i].wd[1:0]}));
      @(posedge clk_in);
    end
    // Master enable clear blocks service with status all
    wr(A_PSW, 32'h0);
    wr(A_PRIO, 32'h0);
    #1;
    chk(32'(srv), 32'h0);
    @(posedge clk_in);
    // Skip flags survive a software write
    hw(1'b0, 1'b0, 3'h5, 1'b0);
    chk(32'(skip), 32'h5);
    wr(A_PSW, 32'h0);
    rd_chk(A_PSW, 32'h50);
    // Set wins over a clear in the same cycle
    hw(1'b0, 1'b0, 3'h2, 1'b1);
    rd_chk(A_PSW, 32'h20);
    hw(1'b0, 1'b0, 3'h0, 1'b1);
    rd_chk(A_PSW, 32'h0);
    // Carry written by the core
    hw(1'b1, 1'b1, 3'h0, 1'b0);
    rd_chk(A_PSW, 32'h80);
    hw(1'b1, 1'b0, 3'h0, 1'b0);
    rd_chk(A_PSW, 32'h0);
    // Write-only and unmapped places read zero
    wr(A_POWER_CONTROL, 32'h0);
    rd_chk(A_POWER_CONTROL, 32'h0);
    rd_chk(32'h100, 32'h0);
    // Divider ratios in normal mode
    period(64);
    wr(A_POWER_CONTROL, 32'h2);
    period(8);
    wr(A_POWER_CONTROL, 32'h3);
    period(4);
    // Idle then stop, each left by wake
    for (int m = 1; m <= 2; m++) begin
      wr(A_POWER_CONTROL, 32'(m * 4 + 3));
      n = 0;
      repeat (20) begin
        @(posedge clk_in);
        #1;
        if (tick !== 1'b0) n++;
      end
      chk(32'({idle, stop}), (m == 1) ? 32'h2 : 32'h1);
      chk(32'(n), 32'h0);
      @(posedge clk_in);
      wake <= 1'b1;
      @(posedge clk_in);
      wake <= 1'b0;
      #1;
      chk(32'({idle, stop}), 32'h0);
      @(posedge clk_in);
      period(4);
    end
    // Reset taken in idle keeps carry and clears the rest; the bus runs at once
    hw(1'b1, 1'b1, 3'h0, 1'b0);
    wr(A_POWER_CONTROL, 32'h4);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk(32'({carry, idle, stop}), 32'h4);
    chk(32'({tick, srv, is, skip, mem_bank_enable, reg_bank_enable}), 32'h0);
    chk(hrdata, 32'h0);
    chk(32'({hresp, hreadyout}), 32'h1);
    rd_chk(A_PSW, 32'h80);
    // Reset taken in normal clears carry and brings back divide by 64
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk(32'(carry), 32'h0);
    period(64);
    final_report();
  end
endmodule : cpsw_tb_top
